// >>> pkg/wiegand_pkg.sv
package wiegand_pkg;

   // Clock rate and the microsecond divider derived from it.
   localparam int unsigned CLK_MHZ         = 100;
   localparam int unsigned US_DIV_CYC      = CLK_MHZ;
   localparam int unsigned US_PER_MS       = 1000;

   // Nominal line timing, in the units in which it is specified.
   localparam int unsigned BIT_PULSE_WIDTH_US     = 100;
   localparam int unsigned BIT_PERIOD_US          = 1000;
   localparam int unsigned INTER_BIT_IDLE_TIME_US =
      BIT_PERIOD_US - BIT_PULSE_WIDTH_US;
   localparam int unsigned STROBE_LEAD_TIME_MS    = 10;
   localparam int unsigned STROBE_TRAIL_TIME_MS   = 10;
   localparam int unsigned STROBE_LEAD_TIME_US    =
      STROBE_LEAD_TIME_MS * US_PER_MS;
   localparam int unsigned STROBE_TRAIL_TIME_US   =
      STROBE_TRAIL_TIME_MS * US_PER_MS;

   // Counter widths.
   localparam int unsigned TIMER_W  = 24;
   localparam int unsigned DIV_W    = 8;

   // Frame geometry; the frame register is left aligned, position 1 on top.
   localparam int unsigned FRAME_W      = 33;
   localparam logic [5:0]  FRAME_LEN_26 = 6'h1a;
   localparam logic [5:0]  FRAME_LEN_33 = 6'h21;
   localparam int unsigned SITE8_W      = 8;
   localparam int unsigned HALF12_W     = 12;
   localparam int unsigned PAD_26_W     = FRAME_W - 26;

   // Card data buffering.
   localparam int unsigned FIFO_DEPTH   = 32;

   // Frame format selection.
   typedef enum logic {
      FMT_26 = 1'b0,
      FMT_33 = 1'b1
   } frame_fmt_t;

   // One recognised identification medium.
   typedef struct packed {
      logic [15:0] site_code;
      logic [15:0] user_number;
   } card_data_t;

   // Static configuration from the controller.
   typedef struct packed {
      frame_fmt_t fmt;
      logic       strobe_en;
   } tx_cfg_t;

   localparam int unsigned CARD_W = $bits(card_data_t);

endpackage

// >>> verilog/card_fifo.sv
`timescale 1ns/10ps

// Synchronous FIFO with registered full and empty flags.
module card_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic [AW:0]      count_nxt;
   wire              push;
   wire              pop;

   // Handshakes on both sides.
   assign push       = in_valid_i && in_ready_o;
   assign pop        = out_valid_o && out_ready_i;
   assign count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data_o = mem[rd_ptr_r];

   // Storage has no reset; only the words that were pushed are ever read.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_i;
      end
   end

   // Pointers, fill level and flags, all registered.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_r    <= '0;
         rd_ptr_r    <= '0;
         count_r     <= '0;
         in_ready_o  <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + AW'(1);
         end
         count_r     <= count_nxt;
         in_ready_o  <= count_nxt != (AW+1)'(DEPTH);
         out_valid_o <= count_nxt != '0;
      end
   end

endmodule // card_fifo

// >>> verilog/wiegand_card_data_transmitter.sv
`timescale 1ns/10ps

module wiegand_card_data_transmitter #(
   parameter int unsigned BIT_PULSE_US   = wiegand_pkg::BIT_PULSE_WIDTH_US,
   parameter int unsigned IDLE_GAP_US    =
      wiegand_pkg::INTER_BIT_IDLE_TIME_US,
   parameter int unsigned STROBE_LEAD_US = wiegand_pkg::STROBE_LEAD_TIME_US,
   parameter int unsigned STROBE_TRAIL_US =
      wiegand_pkg::STROBE_TRAIL_TIME_US
) (
   input  wire logic                   mclk_i,
   input  wire logic                   reset_n_i,
   input  wire logic                   card_valid_i,
   output logic                        card_ready_o,
   input  wire wiegand_pkg::card_data_t card_data_i,
   input  wire wiegand_pkg::tx_cfg_t   cfg_i,
   output logic                        data_zero_o,
   output logic                        data_zero_oe_o,
   output logic                        data_one_o,
   output logic                        data_one_oe_o,
   output logic                        card_present_strobe_o,
   output logic                        card_present_strobe_oe_o,
   output logic                        busy_o,
   output logic                        frame_sent_o
);

   // Transmitter states.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_LEAD  = 3'h1,
      ST_PULSE = 3'h2,
      ST_GAP   = 3'h3,
      ST_TRAIL = 3'h4,
      ST_REST  = 3'h5
   } tx_state_t;

   localparam logic [wiegand_pkg::DIV_W-1:0] DIV_LAST =
      wiegand_pkg::DIV_W'(wiegand_pkg::US_DIV_CYC - 1);
   localparam logic [wiegand_pkg::TIMER_W-1:0] PULSE_LOAD =
      wiegand_pkg::TIMER_W'(BIT_PULSE_US - 1);
   localparam logic [wiegand_pkg::TIMER_W-1:0] GAP_LOAD =
      wiegand_pkg::TIMER_W'(IDLE_GAP_US - 1);
   localparam logic [wiegand_pkg::TIMER_W-1:0] LEAD_LOAD =
      wiegand_pkg::TIMER_W'(STROBE_LEAD_US - 1);
   localparam logic [wiegand_pkg::TIMER_W-1:0] TRAIL_LOAD =
      wiegand_pkg::TIMER_W'(STROBE_TRAIL_US - 1);

   // Parity of a 16-bit word; odd parity is its complement.
   function automatic logic even_par(input logic [15:0] v);
      even_par = ^v;
   endfunction

   // Build a left aligned 33-bit shift image of a 26-bit frame.
   function automatic logic [wiegand_pkg::FRAME_W-1:0] build_26(
      input wiegand_pkg::card_data_t c);
      logic [23:0] body;
      logic        lead_par;
      logic        tail_par;
      body     = {c.site_code[wiegand_pkg::SITE8_W-1:0], c.user_number};
      lead_par = even_par({4'h0, body[23:12]});
      tail_par = ~even_par({4'h0, body[11:0]});
      build_26 = {lead_par, body, tail_par, {wiegand_pkg::PAD_26_W{1'b0}}};
   endfunction

   // Build a 33-bit frame: site code, user number, odd parity.
   function automatic logic [wiegand_pkg::FRAME_W-1:0] build_33(
      input wiegand_pkg::card_data_t c);
      logic par;
      par      = ~(even_par(c.site_code) ^ even_par(c.user_number));
      build_33 = {c.site_code, c.user_number, par};
   endfunction

   // Reset release synchroniser; assertion stays asynchronous.
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Recognised media queue here, so a burst of up to FIFO_DEPTH cards does not
   // stall the reader path while a slow frame is still on the wire.
   wiegand_pkg::card_data_t fifo_data;
   logic                    fifo_valid;
   wire                     fifo_pop;

   card_fifo #(
      .WIDTH (wiegand_pkg::CARD_W),
      .DEPTH (wiegand_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (mclk_i),
      .rst_n_i     (rst_n),
      .in_valid_i  (card_valid_i),
      .in_ready_o  (card_ready_o),
      .in_data_i   (card_data_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   // State and datapath registers.
   tx_state_t                         state_r;
   tx_state_t                         state_nxt;
   logic [wiegand_pkg::FRAME_W-1:0]   frame_r;
   logic [wiegand_pkg::FRAME_W-1:0]   frame_nxt;
   logic [5:0]                        bits_left_r;
   logic [5:0]                        bits_left_nxt;
   logic                              strobe_en_r;
   logic [wiegand_pkg::TIMER_W-1:0]   timer_r;
   logic [wiegand_pkg::TIMER_W-1:0]   timer_nxt;
   logic [wiegand_pkg::DIV_W-1:0]     div_r;
   logic [wiegand_pkg::TIMER_W-1:0]   load_val;

   wire                               start;
   wire                               us_tick;
   wire                               timer_done;
   wire                               last_bit;
   wire                               state_change;
   wire [wiegand_pkg::FRAME_W-1:0]    new_frame;
   wire [5:0]                         new_len;

   // Frame start decode: only a queued, recognised medium starts a frame.
   assign start     = (state_r == ST_IDLE) && fifo_valid;
   assign fifo_pop  = start;
   assign new_frame = (cfg_i.fmt == wiegand_pkg::FMT_33) ?
                      build_33(fifo_data) : build_26(fifo_data);
   assign new_len   = (cfg_i.fmt == wiegand_pkg::FMT_33) ?
                      wiegand_pkg::FRAME_LEN_33 :
                      wiegand_pkg::FRAME_LEN_26;

   // Microsecond divider; it restarts with every state so that each
   // interval is an exact multiple of one microsecond.
   assign us_tick      = div_r == DIV_LAST;
   assign timer_done   = us_tick && (timer_r == '0);
   assign last_bit     = bits_left_r == 6'h01;
   assign state_change = state_nxt != state_r;

   // Next-state logic for the frame sequencer.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (start) begin
               state_nxt = cfg_i.strobe_en ? ST_LEAD : ST_PULSE;
            end
         end
         ST_LEAD: begin
            if (timer_done) begin
               state_nxt = ST_PULSE;
            end
         end
         ST_PULSE: begin
            if (timer_done) begin
               if (!last_bit) begin
                  state_nxt = ST_GAP;
               end else if (strobe_en_r) begin
                  state_nxt = ST_TRAIL;
               end else begin
                  state_nxt = ST_REST;
               end
            end
         end
         ST_GAP: begin
            if (timer_done) begin
               state_nxt = ST_PULSE;
            end
         end
         ST_TRAIL: begin
            if (timer_done) begin
               state_nxt = ST_REST;
            end
         end
         ST_REST: begin
            if (timer_done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Duration of the state being entered, in microseconds minus one.
   always_comb begin
      unique case (state_nxt)
         ST_LEAD:  load_val = LEAD_LOAD;
         ST_PULSE: load_val = PULSE_LOAD;
         ST_TRAIL: load_val = TRAIL_LOAD;
         default:  load_val = GAP_LOAD;
      endcase
   end

   // Interval timer: loaded on every transition, counted by the tick.
   assign timer_nxt = state_change ? load_val :
                      (us_tick ? timer_r - wiegand_pkg::TIMER_W'(1) : timer_r);

   // Frame shift: a new frame on start, one position on each pulse end.
   assign frame_nxt = start ? new_frame :
                      ((state_r == ST_PULSE) && timer_done) ?
                      {frame_r[wiegand_pkg::FRAME_W-2:0], 1'b0} :
                      frame_r;
   assign bits_left_nxt = start ? new_len :
                      ((state_r == ST_PULSE) && timer_done) ?
                      bits_left_r - 6'h01 : bits_left_r;

   // Output enables for the next cycle, so every pin comes from a flop.
   wire zero_oe_nxt;
   wire one_oe_nxt;
   wire strobe_oe_nxt;
   wire strobe_en_nxt;

   assign strobe_en_nxt = start ? cfg_i.strobe_en : strobe_en_r;
   assign zero_oe_nxt   = (state_nxt == ST_PULSE) &&
                          !frame_nxt[wiegand_pkg::FRAME_W-1];
   assign one_oe_nxt    = (state_nxt == ST_PULSE) &&
                          frame_nxt[wiegand_pkg::FRAME_W-1];
   // The strobe covers the lead, every bit and the trail, then releases.
   assign strobe_oe_nxt = strobe_en_nxt &&
                          (state_nxt != ST_IDLE) &&
                          (state_nxt != ST_REST);

   // Sequencer, timer and divider registers.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= ST_IDLE;
         timer_r     <= '0;
         div_r       <= '0;
         frame_r     <= '0;
         bits_left_r <= '0;
         strobe_en_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         timer_r     <= timer_nxt;
         div_r       <= (state_change || us_tick) ? '0 :
                        div_r + wiegand_pkg::DIV_W'(1);
         frame_r     <= frame_nxt;
         bits_left_r <= bits_left_nxt;
         strobe_en_r <= strobe_en_nxt;
      end
   end

   // Pin registers. The level of each line is held at zero and only the
   // enable moves, so a released line is left to the host's pull-up and
   // never driven high against another driver on the same wire.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         data_zero_o              <= 1'b0;
         data_one_o               <= 1'b0;
         card_present_strobe_o    <= 1'b0;
         data_zero_oe_o           <= 1'b0;
         data_one_oe_o            <= 1'b0;
         card_present_strobe_oe_o <= 1'b0;
      end else begin
         data_zero_o              <= 1'b0;
         data_one_o               <= 1'b0;
         card_present_strobe_o    <= 1'b0;
         data_zero_oe_o           <= zero_oe_nxt;
         data_one_oe_o            <= one_oe_nxt;
         card_present_strobe_oe_o <= strobe_oe_nxt;
      end
   end

   // Status: busy from frame start to the end of the rest gap, and a
   // one-cycle pulse when the last bit or trailing strobe has finished.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         busy_o       <= 1'b0;
         frame_sent_o <= 1'b0;
      end else begin
         busy_o       <= state_nxt != ST_IDLE;
         frame_sent_o <= (state_nxt == ST_REST) && (state_r != ST_REST);
      end
   end

endmodule // wiegand_card_data_transmitter

// >>> sim/wiegand_tx_sva.sv
`timescale 1ns/10ps

// Line timing and framing checks, seen from the transmitter's ports.
module wiegand_tx_sva #(
   parameter int unsigned BIT_PULSE_US    = 2,
   parameter int unsigned IDLE_GAP_US     = 3,
   parameter int unsigned STROBE_TRAIL_US = 5
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic card_ready_o,
   input wire logic data_zero_o,
   input wire logic data_zero_oe_o,
   input wire logic data_one_o,
   input wire logic data_one_oe_o,
   input wire logic card_present_strobe_o,
   input wire logic card_present_strobe_oe_o,
   input wire logic busy_o,
   input wire logic frame_sent_o
);
   localparam int PULSE_CYC = BIT_PULSE_US * 100;
   localparam int GAP_CYC   = IDLE_GAP_US * 100;
   localparam int TRAIL_CYC = STROBE_TRAIL_US * 100;
   logic [23:0] since_fall_r;
   wire         data_oe = data_zero_oe_o || data_one_oe_o;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   // Cycles since a pulse ended; it saturates so a long idle never wraps.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) since_fall_r <= '1;
      else if ($fell(data_oe)) since_fall_r <= 24'h000001;
      else if (since_fall_r != '1) since_fall_r <= since_fall_r + 24'h000001;
   end

   // A pulse ends exactly one pulse width after it began.
   sequence s_zero_end;
      ##PULSE_CYC $fell(data_zero_oe_o);
   endsequence
   sequence s_one_end;
      ##PULSE_CYC $fell(data_one_oe_o);
   endsequence

   zero_width_a: assert property ($rose(data_zero_oe_o) |-> s_zero_end)
      else $error("data-zero pulse width wrong");
   one_width_a: assert property ($rose(data_one_oe_o) |-> s_one_end)
      else $error("data-one pulse width wrong");
   no_overlap_a: assert property (!(data_zero_oe_o && data_one_oe_o))
      else $error("both data lines pulled together");
   idle_gap_a: assert property ($rose(data_oe) |-> since_fall_r >= GAP_CYC)
      else $error("idle time between pulses too short");
   trail_end_a: assert property ($fell(card_present_strobe_oe_o) |->
      frame_sent_o && since_fall_r == TRAIL_CYC)
      else $error("strobe released at the wrong time");
   busy_cover_a: assert property ((data_oe || card_present_strobe_oe_o)
      |-> busy_o)
      else $error("lines driven outside a frame");
   release_only_a: assert property (!data_zero_o && !data_one_o &&
      !card_present_strobe_o)
      else $error("line driven high");
   sent_once_a: assert property (frame_sent_o |=> !frame_sent_o)
      else $error("frame end pulse too long");
   reset_idle_a: assert property ($rose(reset_n_i) |->
      !card_ready_o && !busy_o)
      else $error("not idle after reset");
endmodule // wiegand_tx_sva

// >>> sim/wiegand_host_model.sv
`timescale 1ns/10ps

// Receiving host: assembles pulses and checks the timing it sees.
module wiegand_host_model #(
   parameter int PULSE_CYC  = 200,
   parameter int PERIOD_CYC = 500
) (
   input  wire logic        clk_i,
   input  wire logic        clear_i,
   input  wire logic        zero_line_i,
   input  wire logic        one_line_i,
   input  wire logic        strobe_line_i,
   output logic [32:0]      bits_o,
   output logic [5:0]       cnt_o,
   output logic [23:0]      lead_o,
   output logic [23:0]      trail_o,
   output logic             bad_o
);
   logic        low_q    = 1'b0;
   logic        strobe_q = 1'b1;
   logic [23:0] rise_t   = '0;
   logic [23:0] fall_t   = '0;
   logic [23:0] sfall_t  = '0;
   wire low         = !zero_line_i || !one_line_i;
   wire pulse_start = low && !low_q;
   wire pulse_end   = !low && low_q;
   wire width_bad   = pulse_end && (rise_t < PULSE_CYC * 8 / 10 ||
      rise_t > PULSE_CYC * 12 / 10);
   wire period_bad  = pulse_start && cnt_o != 6'h00 &&
      (rise_t < PERIOD_CYC * 9 / 10 || rise_t > PERIOD_CYC * 11 / 10);

   // Behavioural: timers restart on line edges; clear starts a new frame.
   always @(posedge clk_i) begin
      low_q <= low;
      strobe_q <= strobe_line_i;
      rise_t <= pulse_start ? 24'h000001 : rise_t + 24'h000001;
      fall_t <= pulse_end ? 24'h000001 : fall_t + 24'h000001;
      sfall_t <= (!strobe_line_i && strobe_q) ? 24'h000001 :
         sfall_t + 24'h000001;
      if (strobe_line_i && !strobe_q) trail_o <= fall_t;
      if (pulse_start && cnt_o == 6'h00) lead_o <= sfall_t;
      if (pulse_start) bits_o <= {bits_o[31:0], !one_line_i};
      if (pulse_start) cnt_o <= cnt_o + 6'h01;
      if (width_bad || period_bad || (!zero_line_i && !one_line_i)) bad_o <= 1'b1;
      if (clear_i) begin
         bits_o <= '0;
         cnt_o <= '0;
         bad_o <= 1'b0;
      end
   end
endmodule // wiegand_host_model

// >>> sim/wiegand_card_data_transmitter_test.sv
`timescale 1ns/10ps

// Self-checking bench; short timing parameters keep the run brief.
module wiegand_card_data_transmitter_test;
   localparam int unsigned PU = 2;
   localparam int unsigned GP = 3;
   localparam int unsigned LD = 5;
   localparam int unsigned TR = 5;
   logic                    mclk_i       = 1'b0;
   logic                    reset_n_i    = 1'b0;
   logic                    card_valid_i = 1'b0;
   logic                    clear        = 1'b0;
   wiegand_pkg::card_data_t card_data_i  = '0;
   wiegand_pkg::tx_cfg_t    cfg_i        = '0;
   logic                    card_ready_o, busy_o, frame_sent_o;
   logic                    z_o, z_oe, o_o, o_oe, s_o, s_oe, rx_bad;
   logic [32:0]             rx_bits;
   logic [5:0]              rx_cnt;
   logic [23:0]             lead, trail;
   int                      error_cnt = 0;
   int                      n_tests   = 0;
   // Host pull-ups: a released line reads high.
   wire zero_line = z_oe ? z_o : 1'b1;
   wire one_line  = o_oe ? o_o : 1'b1;
   wire strb_line = s_oe ? s_o : 1'b1;

   wiegand_card_data_transmitter #(.BIT_PULSE_US(PU), .IDLE_GAP_US(GP),
      .STROBE_LEAD_US(LD), .STROBE_TRAIL_US(TR))
   wiegand_card_data_transmitter_inst (.mclk_i(mclk_i),
      .reset_n_i(reset_n_i), .card_valid_i(card_valid_i),
      .card_ready_o(card_ready_o), .card_data_i(card_data_i), .cfg_i(cfg_i),
      .data_zero_o(z_o), .data_zero_oe_o(z_oe), .data_one_o(o_o),
      .data_one_oe_o(o_oe), .card_present_strobe_o(s_o),
      .card_present_strobe_oe_o(s_oe), .busy_o(busy_o),
      .frame_sent_o(frame_sent_o));

   wiegand_host_model #(.PULSE_CYC(PU * 100), .PERIOD_CYC((PU + GP) * 100))
   wiegand_host_model_inst (.clk_i(mclk_i), .clear_i(clear),
      .zero_line_i(zero_line), .one_line_i(one_line),
      .strobe_line_i(strb_line), .bits_o(rx_bits), .cnt_o(rx_cnt),
      .lead_o(lead), .trail_o(trail), .bad_o(rx_bad));

   // Free-running 100 MHz clock.
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   task automatic check(input string what, input logic [32:0] seen,
      input logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Expected frames, position 1 in the most significant place.
   function automatic logic [32:0] f26(input wiegand_pkg::card_data_t c);
      return {7'h00, ^{c.site_code[7:0], c.user_number[15:12]},
         c.site_code[7:0], c.user_number, ~^c.user_number[11:0]};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   // Holds valid and data until the edge that takes them. Valid stays up
   // between back-to-back cards, so it is never lowered and raised again
   // in one time step; it drops only after the last card of a burst.
   task automatic push(input wiegand_pkg::card_data_t c, input logic last);
      card_data_i = c;
      card_valid_i = 1'b1;
      while (card_ready_o !== 1'b1) tick(1);
      tick(1);
      if (last) card_valid_i = 1'b0;
   endtask

   task automatic new_frame(input logic fmt, input logic en);
      cfg_i = {fmt, en};
      clear = 1'b1;
      tick(1);
      clear = 1'b0;
   endtask

   // Waits for the end-of-frame pulse, then judges what the host got.
   task automatic judge(input logic [5:0] len, input logic [32:0] exp,
      input logic strb);
      int n;
      n = 0;
      while (frame_sent_o !== 1'b1 && n < 40000) begin
         tick(1);
         n++;
      end
      tick(4);
      check("frame end", {32'h0, n < 40000}, 33'h1);
      check("bit count", {27'h0, rx_cnt}, {27'h0, len});
      check("frame bits", rx_bits, exp);
      check("host timing", {32'h0, rx_bad}, 33'h0);
      if (strb) begin
         check("strobe lead", {9'h0, lead}, 33'(LD * 100));
         check("strobe trail", {9'h0, trail}, 33'(TR * 100));
      end
   endtask

   task automatic s_idle();
      tick(1000);
      check("idle busy", {32'h0, busy_o}, 33'h0);
      check("idle pulses", {27'h0, rx_cnt}, 33'h0);
   endtask

   // Upper site byte must be dropped in the short format.
   task automatic s_fmt26();
      new_frame(1'b0, 1'b1);
      push({16'h12a5, 16'hbeef}, 1'b1);
      judge(6'h1a, f26({16'h12a5, 16'hbeef}), 1'b1);
   endtask

   // A strobe enable change mid-frame must not alter the frame in flight.
   task automatic s_fmt33();
      new_frame(1'b1, 1'b0);
      push({16'hc3a6, 16'h0f01}, 1'b1);
      tick(600);
      cfg_i = '1;
      judge(6'h21, {16'hc3a6, 16'h0f01, ~^32'hc3a60f01}, 1'b0);
   endtask

   // Two cards queued back to back leave in push order.
   task automatic s_b2b();
      new_frame(1'b0, 1'b0);
      push({16'h00ff, 16'h0001}, 1'b0);
      push({16'hff00, 16'hfffe}, 1'b1);
      judge(6'h1a, f26({16'h00ff, 16'h0001}), 1'b0);
      new_frame(1'b0, 1'b0);
      judge(6'h1a, f26({16'hff00, 16'hfffe}), 1'b0);
   endtask

   // Fill until refused, then a mid-run reset empties the queue.
   task automatic s_fill();
      int  n;
      logic ok;
      n = 0;
      // The sequencer must be idle so that it pops exactly one word.
      while (busy_o !== 1'b0) tick(1);
      new_frame(1'b0, 1'b0);
      card_valid_i = 1'b1;
      do begin
         card_data_i = {16'h0055, 16'(n)};
         ok = card_ready_o;
         tick(1);
         if (ok === 1'b1) n++;
      end while (ok === 1'b1 && n < 40);
      tick(20);
      check("ready when full", {32'h0, card_ready_o}, 33'h0);
      check("words taken", 33'(n), 33'(wiegand_pkg::FIFO_DEPTH + 1));
      card_valid_i = 1'b0;
      reset_n_i = 1'b0;
      tick(2);
      check("lines in reset", {30'h0, z_oe, o_oe, s_oe}, 33'h0);
      reset_n_i = 1'b1;
      tick(1000);
      check("ready again", {32'h0, card_ready_o}, 33'h1);
      check("queue emptied", {32'h0, busy_o}, 33'h0);
   endtask

   // Main sequence.
   initial begin
      tick(2);
      reset_n_i = 1'b1;
      new_frame(1'b0, 1'b0);
      s_idle();
      s_fmt26();
      s_fmt33();
      s_b2b();
      s_fill();
      wrap_up();
   end

   // Watchdog: the scenarios need about 60,000 cycles, this allows 90,000.
   initial begin
      #900000;
      error_cnt++;
      wrap_up();
   end
endmodule // wiegand_card_data_transmitter_test

bind wiegand_card_data_transmitter wiegand_tx_sva #(
   .BIT_PULSE_US(BIT_PULSE_US),
   .IDLE_GAP_US(IDLE_GAP_US),
   .STROBE_TRAIL_US(STROBE_TRAIL_US)
) wiegand_tx_sva_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
   .card_ready_o(card_ready_o), .data_zero_o(data_zero_o),
   .data_zero_oe_o(data_zero_oe_o), .data_one_o(data_one_o),
   .data_one_oe_o(data_one_oe_o),
   .card_present_strobe_o(card_present_strobe_o),
   .card_present_strobe_oe_o(card_present_strobe_oe_o),
   .busy_o(busy_o), .frame_sent_o(frame_sent_o));
